//--- hw/pbt_blank_timing.sv
/*
 * pbt_blank_timing: programmable blank output and pixel input gate.
 * Assumes sync edge pulses and the 1x pixel enable come from logic on clk,
 * and the host register port delivers one-cycle requests on clk.
 */
module pbt_blank_timing #(
    parameter int HCNT_W = 10,
    parameter int LINE_W = 10
) (
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire pbt_pkg::pbt_reg_req_t reg_req,
    output logic [7:0]                reg_rdata,
    output logic                      reg_rvalid,
    input  wire pbt_pkg::pbt_timing_t timing,
    input  wire logic                 blank_is_output,
    input  wire logic                 quarter_res_input_mode,
    input  wire logic                 std_625_line,
    output logic                      blank_out,
    output logic                      pixel_accept
);
    import pbt_pkg::*;

    // ========================================================================
    // parameter guard
    // ========================================================================
    // the compare datapath and the package references are ten bits wide;
    // other widths would silently truncate the start and line compares
    if (HCNT_W != 10 || LINE_W != 10) begin : g_width_check
        $error("pbt_blank_timing: counter widths not supported");
    end

    // ========================================================================
    // helper functions
    // ========================================================================
    // one write decode for every register; reads never change state
    function automatic logic wr_hit(
        input pbt_reg_req_t req,
        input logic [7:0]   ofs
    );
        wr_hit = req.valid && req.write && (req.addr == ofs);
    endfunction : wr_hit

    // vertical compare: blanking stands from line n to the next odd vsync
    function automatic logic line_reached(
        input logic [9:0] line,
        input logic [9:0] first
    );
        line_reached = (line >= first);
    endfunction : line_reached

    // ========================================================================
    // register file
    // ========================================================================
    logic [7:0] hbs_low_reg;
    logic [1:0] hbs_high_reg;
    logic [7:0] hbe_reg;
    logic [7:0] vbs_low_reg;
    logic [0:0] vbs_high_reg;
    logic [7:0] vbe_reg;

    // horizontal start, low byte; a write lands on the next cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            hbs_low_reg <= PBT_RST_HBS_LOW;
        end else if (wr_hit(reg_req, PBT_OFS_HBS_LOW)) begin
            hbs_low_reg <= reg_req.wdata;
        end
    end

    // horizontal start, two high bits; reserved bits are not stored
    always_ff @(posedge clk) begin
        if (srst) begin
            hbs_high_reg <= PBT_RST_HBS_HIGH;
        end else if (wr_hit(reg_req, PBT_OFS_HBS_HIGH)) begin
            hbs_high_reg <= reg_req.wdata[PBT_HBS_HIGH_W-1:0];
        end
    end

    // horizontal end, a plain byte in the sync-referenced count
    always_ff @(posedge clk) begin
        if (srst) begin
            hbe_reg <= PBT_RST_HBE;
        end else if (wr_hit(reg_req, PBT_OFS_HBE)) begin
            hbe_reg <= reg_req.wdata;
        end
    end

    // vertical start, low byte
    always_ff @(posedge clk) begin
        if (srst) begin
            vbs_low_reg <= PBT_RST_VBS_LOW;
        end else if (wr_hit(reg_req, PBT_OFS_VBS_LOW)) begin
            vbs_low_reg <= reg_req.wdata;
        end
    end

    // vertical start, ninth bit; a host changing both bytes sees a
    // mixed value from the first write until the second one lands
    always_ff @(posedge clk) begin
        if (srst) begin
            vbs_high_reg <= PBT_RST_VBS_HIGH;
        end else if (wr_hit(reg_req, PBT_OFS_VBS_HIGH)) begin
            vbs_high_reg <= reg_req.wdata[PBT_VBS_HIGH_W-1:0];
        end
    end

    // vertical end: kept only so its address reads back, drives nothing
    always_ff @(posedge clk) begin
        if (srst) begin
            vbe_reg <= PBT_RST_VBE;
        end else if (wr_hit(reg_req, PBT_OFS_VBE)) begin
            vbe_reg <= reg_req.wdata;
        end
    end

    // readback; reserved bits and unmapped addresses read zero
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.valid && !reg_req.write;
            case (reg_req.addr)
                PBT_OFS_HBS_LOW:  reg_rdata <= hbs_low_reg;
                PBT_OFS_HBS_HIGH: reg_rdata <= {6'h00, hbs_high_reg};
                PBT_OFS_HBE:      reg_rdata <= hbe_reg;
                PBT_OFS_VBS_LOW:  reg_rdata <= vbs_low_reg;
                PBT_OFS_VBS_HIGH: reg_rdata <= {7'h00, vbs_high_reg};
                PBT_OFS_VBE:      reg_rdata <= vbe_reg;
                default:          reg_rdata <= 8'h00;
            endcase
        end
    end

    // ========================================================================
    // compare values
    // ========================================================================
    logic [9:0] hblank_start;
    logic [9:0] hblank_end;
    logic [9:0] vblank_start;
    logic [9:0] even_ofs;
    logic [9:0] vblank_start_even;

    assign hblank_start      = {hbs_high_reg, hbs_low_reg};
    assign hblank_end        = {2'b00, hbe_reg};
    assign vblank_start      = {1'b0, vbs_high_reg, vbs_low_reg};
    assign even_ofs          = std_625_line ? PBT_EVEN_OFS_625 : PBT_EVEN_OFS_525;
    assign vblank_start_even = vblank_start + even_ofs;

    // ========================================================================
    // counters
    // ========================================================================
    // count is end-referenced (sync edge = 0); start compare adds the offset
    logic [9:0] hcnt_reg;
    logic [9:0] line_reg;
    logic       odd_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            hcnt_reg <= PBT_HEND_AT_SYNC;
        end else if (timing.hsync_lead) begin
            hcnt_reg <= PBT_HEND_AT_SYNC;
        end else if (timing.pix_en && hcnt_reg != 10'h3ff) begin
            hcnt_reg <= hcnt_reg + 10'h001;
        end
    end

    // line count: saturates so a missing vsync cannot wrap into line n
    always_ff @(posedge clk) begin
        if (srst) begin
            line_reg <= PBT_LINE_AT_SYNC;
        end else if (timing.vsync_lead && timing.odd_field) begin
            line_reg <= PBT_LINE_AT_SYNC;
        end else if (timing.hsync_lead && line_reg != 10'h3ff) begin
            line_reg <= line_reg + 10'h001;
        end
    end

    // field flag: any vsync picks the field; only odd clears the count
    always_ff @(posedge clk) begin
        if (srst) begin
            odd_reg <= 1'b1;
        end else if (timing.vsync_lead) begin
            odd_reg <= timing.odd_field;
        end
    end

    // ========================================================================
    // blanking decisions
    // ========================================================================
    logic h_start_hit;
    logic h_end_hit;
    logic v_out_blank;
    logic v_in_stop;
    pbt_hstate_t hstate_reg;

    assign h_start_hit = (hcnt_reg + PBT_HOFS_START) == hblank_start;
    assign h_end_hit   = hcnt_reg == hblank_end;
    // output vertical blank: line n in odd field, n plus offset in even
    assign v_out_blank = odd_reg ? line_reached(line_reg, vblank_start)
                                 : line_reached(line_reg, vblank_start_even);
    // quarter-res source is noninterlaced: input stops at n of each frame
    assign v_in_stop   = quarter_res_input_mode ? line_reached(line_reg, vblank_start) : v_out_blank;

    // horizontal state: start checked only while active, end only while blank; a shared count toggles state each line
    always_ff @(posedge clk) begin
        if (srst) begin
            hstate_reg <= PBT_H_ACTIVE;
        end else if (timing.pix_en) begin
            case (hstate_reg)
                PBT_H_ACTIVE: if (h_start_hit) hstate_reg <= PBT_H_BLANK;
                PBT_H_BLANK:  if (h_end_hit) hstate_reg <= PBT_H_ACTIVE;
                default:      hstate_reg <= PBT_H_ACTIVE;
            endcase
        end
    end

    // blank output; timing values ignored while the blank pin is an input
    always_ff @(posedge clk) begin
        if (srst) begin
            blank_out <= 1'b0;
        end else if (!blank_is_output) begin
            blank_out <= 1'b0;
        end else begin
            blank_out <= (hstate_reg == PBT_H_BLANK) || v_out_blank;
        end
    end

    // input gate; in quarter-res mode it may close while output is live
    always_ff @(posedge clk) begin
        if (srst) begin
            pixel_accept <= 1'b1;
        end else if (!blank_is_output) begin
            pixel_accept <= 1'b1;
        end else begin
            pixel_accept <= (hstate_reg != PBT_H_BLANK) && !v_in_stop;
        end
    end
endmodule : pbt_blank_timing

//--- hw/pbt_pkg.sv
/*
 * pbt_pkg: register offsets, reset values, counter references and carrier
 * types for the programmable blank timing block.
 * Assumes one 250 MHz clock, with a 1x pixel clock enable made elsewhere.
 */
package pbt_pkg;
    // ========================================================================
    // register offsets (host sub-addresses)
    // ========================================================================
    localparam logic [7:0] PBT_OFS_HBS_LOW  = 8'h20;
    localparam logic [7:0] PBT_OFS_HBS_HIGH = 8'h21;
    localparam logic [7:0] PBT_OFS_HBE      = 8'h22;
    localparam logic [7:0] PBT_OFS_VBS_LOW  = 8'h23;
    localparam logic [7:0] PBT_OFS_VBS_HIGH = 8'h24;
    localparam logic [7:0] PBT_OFS_VBE      = 8'h25;

    // ========================================================================
    // reset values
    // ========================================================================
    localparam logic [7:0] PBT_RST_HBS_LOW  = 8'h4a;
    localparam logic [1:0] PBT_RST_HBS_HIGH = 2'h0;
    localparam logic [7:0] PBT_RST_HBE      = 8'h7a;
    localparam logic [7:0] PBT_RST_VBS_LOW  = 8'h03;
    localparam logic [0:0] PBT_RST_VBS_HIGH = 1'h1;
    localparam logic [7:0] PBT_RST_VBE      = 8'h13;

    // ========================================================================
    // field layout and counter references
    // ========================================================================
    localparam int         PBT_HBS_HIGH_W   = 2;
    localparam int         PBT_VBS_HIGH_W   = 1;
    localparam logic [9:0] PBT_HCNT_AT_SYNC = 10'h020;
    localparam logic [9:0] PBT_HEND_AT_SYNC = 10'h000;
    localparam logic [9:0] PBT_HOFS_START   = PBT_HCNT_AT_SYNC - PBT_HEND_AT_SYNC;
    localparam logic [9:0] PBT_LINE_AT_SYNC = 10'h000;
    localparam logic [9:0] PBT_EVEN_OFS_525 = 10'h106;
    localparam logic [9:0] PBT_EVEN_OFS_625 = 10'h139;

    // ========================================================================
    // carrier types
    // ========================================================================
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pbt_reg_req_t;

    typedef struct packed {
        logic       hsync_lead;
        logic       vsync_lead;
        logic       odd_field;
        logic       pix_en;
    } pbt_timing_t;

    typedef enum logic [1:0] {
        PBT_H_ACTIVE = 2'b00,
        PBT_H_BLANK  = 2'b01
    } pbt_hstate_t;
endpackage : pbt_pkg

//--- test/pbt_blank_timing_asserts.sv
/* checker: port relations of pbt_blank_timing.
   assumes a bind from the bench top. */
module pbt_blank_timing_asserts (
    input wire logic                  clk,
    input wire logic                  srst,
    input wire pbt_pkg::pbt_reg_req_t reg_req,
    input wire logic [7:0]            reg_rdata,
    input wire logic                  reg_rvalid,
    input wire pbt_pkg::pbt_timing_t  timing,
    input wire logic                  blank_is_output,
    input wire logic                  quarter_res_input_mode,
    input wire logic                  std_625_line,
    input wire logic                  blank_out,
    input wire logic                  pixel_accept
);
    import pbt_pkg::*;
    logic [9:0] hc_reg;
    logic [9:0] hbs_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // ====================
    // helpers
    // pixel count from the sync edge
    always_ff @(posedge clk) begin
        if (srst || timing.hsync_lead) hc_reg <= 10'h000;
        else if (timing.pix_en) hc_reg <= hc_reg + 10'h001;
    end
    // start shadow; lands next cycle, as in the block
    always_ff @(posedge clk) begin
        if (srst) hbs_reg <= {PBT_RST_HBS_HIGH, PBT_RST_HBS_LOW};
        else if (reg_req.valid && reg_req.write && reg_req.addr == PBT_OFS_HBS_LOW) hbs_reg[7:0] <= reg_req.wdata;
        else if (reg_req.valid && reg_req.write && reg_req.addr == PBT_OFS_HBS_HIGH) hbs_reg[9:8] <= reg_req.wdata[1:0];
    end
    sequence s_rd;
        reg_req.valid && !reg_req.write;
    endsequence
    chk_start_blank: assert property (blank_is_output && timing.pix_en && !timing.hsync_lead
        && hc_reg + PBT_HCNT_AT_SYNC == hbs_reg |-> ##[1:2] blank_out) else $error("blank start missed");
    chk_off_idle: assert property (!blank_is_output |=> !blank_out && pixel_accept)
        else $error("blank not idle when pin is input");
    chk_blank_input: assert property (blank_out |-> !pixel_accept) else $error("pixels taken in blank");
    chk_normal_pair: assert property (!quarter_res_input_mode && !$past(quarter_res_input_mode)
        && !$past(quarter_res_input_mode, 2) |-> pixel_accept == !blank_out) else $error("gate and blank differ");
    chk_read_answer: assert property (s_rd |=> reg_rvalid) else $error("read not answered");
    chk_no_stray: assert property (!(reg_req.valid && !reg_req.write) |=> !reg_rvalid) else $error("stray answer");
    chk_unmapped_rd: assert property (s_rd ##0 (reg_req.addr < 8'h20 || reg_req.addr > 8'h25)
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    chk_reserved_rd: assert property (s_rd ##0 reg_req.addr == PBT_OFS_HBS_HIGH
        |=> reg_rdata[7:2] == 6'h00) else $error("reserved bits set");
endmodule : pbt_blank_timing_asserts

//--- test/pbt_pix_source.sv
/* pixel source model: sync pulses and 1x pixel enable.
   assumes the block's clock; raster position is exported. */
module pbt_pix_source #(
    parameter int LINE_PIX  = 140,
    parameter int ODD_LINES = 8,
    parameter int ALL_LINES = 320
) (
    input  wire logic                 clk,
    input  wire logic                 srst,
    output pbt_pkg::pbt_timing_t      timing,
    output logic [9:0]                pix,
    output logic [9:0]                line
);
    import pbt_pkg::*;
    // ====================
    // raster; short lines keep the run brief
    always_ff @(posedge clk) begin
        if (srst || pix == LINE_PIX - 1) pix <= 10'h000;
        else pix <= pix + 10'h001;
    end
    // line advances at wrap; line 0 opens the odd field
    always_ff @(posedge clk) begin
        if (srst) line <= 10'h000;
        else if (pix == LINE_PIX - 1) line <= (line == ALL_LINES - 1) ? 10'h000 : line + 10'h001;
    end
    // vsync one pixel after hsync so the line clear wins
    assign timing = '{!srst && pix == 0, pix == 1 && (line == 0 || line == ODD_LINES), line < ODD_LINES, 1'b1};
endmodule : pbt_pix_source

//--- test/testbench.sv
/* bench: registers, horizontal and vertical blank windows.
   assumes pbt_pkg, the model and the checker compiled first. */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pbt_pkg::*;
    logic         clk = 1'b0;
    logic         srst = 1'b1;
    pbt_reg_req_t reg_req = '0;
    logic         blank_is_output = 1'b1;
    logic         quarter_res_input_mode = 1'b0;
    logic         std_625_line = 1'b0;
    logic [7:0]   reg_rdata;
    logic         reg_rvalid, blank_out, pixel_accept;
    pbt_timing_t  timing;
    logic [9:0]   pix, line;
    int           n_errors = 0, checked = 0, cyc = 0;
    pbt_blank_timing u_pbt_blank_timing (.clk(clk), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .timing(timing), .blank_is_output(blank_is_output),
        .quarter_res_input_mode(quarter_res_input_mode), .std_625_line(std_625_line),
        .blank_out(blank_out), .pixel_accept(pixel_accept));
    pbt_pix_source u_pbt_pix_source (.clk(clk), .srst(srst), .timing(timing), .pix(pix), .line(line));
    // ====================
    // clock and hang guard; a frame is about 45k cycles
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_errors++;
            results();
        end
    end
    task automatic results();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) reg_req <= '{1'b1, 1'b1, a, d};
        @(posedge clk) reg_req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) reg_req <= '{1'b1, 1'b0, a, 8'h00};
        @(posedge clk) reg_req <= '0;
        #1 chk("reg_rvalid", reg_rvalid, 8'h01);
        chk("reg_rdata", reg_rdata, exp);
    endtask : rd
    // samples well away from any edge of the windows
    task automatic see(input int l, input int p, input logic eb, input logic ea);
        do @(posedge clk); while (!(line == l && pix == p));
        #1 chk("blank_out", blank_out, eb);
        chk("pixel_accept", pixel_accept, ea);
    endtask : see
    task automatic t_regs();
        rd(8'h20, 8'h4a);
        rd(8'h21, 8'h00);
        rd(8'h22, 8'h7a);
        rd(8'h23, 8'h03);
        rd(8'h26, 8'h00);
        wr(8'h21, 8'hff);
        rd(8'h21, 8'h03);
        wr(8'h21, 8'h00);
    endtask : t_regs
    task automatic t_hwin();
        see(1, 38, 1'b0, 1'b1);
        see(1, 48, 1'b1, 1'b0);
        see(1, 118, 1'b1, 1'b0);
        see(1, 128, 1'b0, 1'b1);
        wr(8'h21, 8'h01);
        see(2, 48, 1'b0, 1'b1);
        wr(8'h21, 8'h00);
        @(posedge clk) blank_is_output <= 1'b0;
        see(3, 48, 1'b0, 1'b1);
        @(posedge clk) blank_is_output <= 1'b1;
    endtask : t_hwin
    task automatic t_vert();
        wr(8'h23, 8'h02);
        wr(8'h24, 8'h00);
        see(4, 20, 1'b1, 1'b0);
        see(10, 20, 1'b0, 1'b1);
        @(posedge clk) quarter_res_input_mode <= 1'b1;
        see(12, 20, 1'b0, 1'b0);
        see(270, 20, 1'b1, 1'b0);
        @(posedge clk) std_625_line <= 1'b1;
        see(280, 20, 1'b0, 1'b0);
        see(318, 20, 1'b1, 1'b0);
        @(posedge clk) quarter_res_input_mode <= 1'b0;
        see(1, 20, 1'b0, 1'b1);
        see(3, 20, 1'b1, 1'b0);
    endtask : t_vert
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_hwin();
        t_vert();
        results();
    end
endmodule : testbench
bind pbt_blank_timing pbt_blank_timing_asserts u_pbt_blank_timing_asserts (.clk(clk), .srst(srst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .timing(timing),
    .blank_is_output(blank_is_output), .quarter_res_input_mode(quarter_res_input_mode),
    .std_625_line(std_625_line), .blank_out(blank_out), .pixel_accept(pixel_accept));
